// *** rtl/pwm_dither_dac_params.svh ***
`ifndef PWM_DITHER_DAC_PARAMS_SVH
`define PWM_DITHER_DAC_PARAMS_SVH

// System clock period in nanoseconds (50 MHz).
`define CLK_PERIOD_NS       20
// Carrier period of the PWM in nanoseconds (16 us).
`define CARRIER_PERIOD_NS   16000
// Carrier period in clock cycles, rounded down.
`define CARRIER_CYC         (`CARRIER_PERIOD_NS / `CLK_PERIOD_NS)
// Number of carrier periods in one dither pattern pass.
`define PASS_STATES         16
// Number of ADC results summed into one measurement.
`define AVG_SAMPLES         16
// Number of ADC samples between two loop corrections.
`define CORR_SAMPLES        256
// Reset value of the 12-bit target code.
`define TARGET_RESET        12'h000
// Field positions of the 12-bit target code.
`define BASE_MSB            11
`define BASE_LSB            4
`define FACTOR_MSB          3
`define FACTOR_LSB          0

`endif

// *** rtl/pwm_dither_dac_pkg.sv ***
package pwm_dither_dac_pkg;

  // Regulation mode of the dither factor.
  typedef enum logic [0:0] {
    MODE_OPEN   = 1'b0,
    MODE_CLOSED = 1'b1
  } loop_mode_e;

  // One ADC result with its strobe.
  typedef struct packed {
    logic       valid;
    logic [9:0] data;
  } adc_sample_s;

  // Setting applied to one whole dither pass.
  typedef struct packed {
    logic [7:0] base;
    logic [3:0] factor;
  } pass_setting_s;

endpackage : pwm_dither_dac_pkg

// *** rtl/pwm_dither_dac.sv ***
`timescale 1ns/1ps
`include "pwm_dither_dac_params.svh"

// Functional notes
// [RULE1] Output is 8-bit PWM, fixed period, duty code one of 256 values.
// [RULE2] A carrier counter sets the period; a compare stage sets the duty.
// [RULE3] Each period uses either the base code or the base code plus one.
// [RULE4] The dither pattern repeats every 16 periods, giving 15 intermediate levels.
// [RULE5] Duty code is updated once per 16 us period; pattern repeats every 256 us.
// [RULE6] Sequencer loads each pattern state by itself and re-arms after state 16.
// [RULE7] Open loop applies the commanded base code and factor without ADC correction.
// [RULE8] Closed loop sums 16 consecutive 10-bit ADC results into a 12-bit measurement.
// [RULE9] Closed loop steps the factor by +1, -1 or 0 after every 256 samples.
// [RULE10] A pattern bit of zero selects base, a one selects base plus one.
// [RULE11] Factor N in 0..15 selects a fixed 16-entry sequence holding N ones.
// [RULE12] The carrier triggers each load; a reload event occurs every 16 loads.
// [RULE13] Upper 8 target bits are the base code, lower 4 the dither factor.
// [RULE14] New base or factor takes effect only at the start of a pass.
module pwm_dither_dac
  import pwm_dither_dac_pkg::*;
#(
  parameter int CARRIER_CYC = `CARRIER_CYC
) (
  input  wire logic                           sys_clk,
  input  wire logic                           resetn,
  input  wire logic [11:0]                    target_code,
  input  wire pwm_dither_dac_pkg::loop_mode_e loop_mode,
  input  wire pwm_dither_dac_pkg::adc_sample_s adc_in,
  output logic                                pwm_out,
  output logic                                transfer_pulse,
  output logic                                reload_pulse,
  output logic                                meas_valid,
  output logic [11:0]                         meas_value,
  output pwm_dither_dac_pkg::pass_setting_s   pass_setting
);
  import pwm_dither_dac_pkg::*;

  // One spare bit so that a power-of-two period still fits the CW-bit operand of the product; the counter needs no spare bit.
  localparam int CW = $clog2(CARRIER_CYC + 1);

  // Fixed adder sequences; bit s is the adder for pattern state s+1.
  function automatic logic [15:0] dither_seq(input logic [3:0] n);
    case (n)
      4'h0:    dither_seq = 16'h0000;
      4'h1:    dither_seq = 16'h0001;
      4'h2:    dither_seq = 16'h0101;
      4'h3:    dither_seq = 16'h0421;
      4'h4:    dither_seq = 16'h1111;
      4'h5:    dither_seq = 16'h1249;
      4'h6:    dither_seq = 16'h2525;
      4'h7:    dither_seq = 16'h2A55;
      4'h8:    dither_seq = 16'h5555;
      4'h9:    dither_seq = 16'hD5AA;
      4'hA:    dither_seq = 16'hDADA;
      4'hB:    dither_seq = 16'hEDB6;
      4'hC:    dither_seq = 16'hEEEE;
      4'hD:    dither_seq = 16'hFBDE;
      4'hE:    dither_seq = 16'hFEFE;
      4'hF:    dither_seq = 16'hFFFE;
      default: dither_seq = 16'h0000;
    endcase
  endfunction : dither_seq

  logic                rst_meta_r;
  logic                rst_sync_n_r;
  logic [CW-1:0]       carrier_cnt_r;
  logic                carrier_wrap;
  logic [3:0]          state_r;
  logic                pass_wrap;
  pass_setting_s       setting_r;
  logic [7:0]          duty_r;
  pass_setting_s       setting_nxt;
  logic [15:0]         seq_word;
  logic                seq_bit;
  logic [8:0]          duty_inc;
  logic [CW+7:0]       thresh_prod;
  logic [CW-1:0]       thresh;
  logic [11:0]         closed_code_r;
  logic [11:0]         applied_code;
  logic [3:0]          avg_cnt_r;
  logic [13:0]         sum_r;
  logic [13:0]         sum_nxt;
  logic [3:0]          block_cnt_r;
  logic                target_prev_mode_r;
  logic [11:0]         target_prev_r;

  // Reset release passes two flip-flops.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r   <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end else begin
      rst_meta_r   <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // Master channel: free running carrier counter fixing the period.
  assign carrier_wrap = (carrier_cnt_r == CW'(CARRIER_CYC - 1));
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      carrier_cnt_r <= '0;
    end else if (carrier_wrap) begin
      carrier_cnt_r <= '0; // [RULE2] [RULE5]
    end else begin
      carrier_cnt_r <= carrier_cnt_r + CW'(1);
    end
  end

  // Pattern state counter advanced by the carrier; it re-arms itself after state 16.
  assign pass_wrap = carrier_wrap && (state_r == 4'(`PASS_STATES - 1));
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      state_r <= 4'h0;
    end else if (carrier_wrap) begin
      state_r <= state_r + 4'h1; // [RULE4] [RULE6] [RULE12]
    end
  end

  // Open loop uses the target directly; closed loop uses the corrected code.
  assign applied_code = (loop_mode == MODE_CLOSED) ? closed_code_r : target_code; // [RULE7]

  // Split of the applied code into the setting that the next pass would use.
  assign setting_nxt = '{base:   applied_code[`BASE_MSB:`BASE_LSB],
                         factor: applied_code[`FACTOR_MSB:`FACTOR_LSB]}; // [RULE13]

  // Base and factor are latched only when a new pass begins.
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      setting_r <= '0;
    end else if (pass_wrap) begin
      setting_r <= setting_nxt; // [RULE14]
    end
  end

  // Transfer: at each carrier wrap the next period's duty code is loaded.
  // The state index of the next period selects the adder bit; base 255 saturates.
  always_comb begin
    seq_word = dither_seq(setting_r.factor);
    seq_bit  = seq_word[state_r + 4'h1]; // [RULE10] [RULE11]
    duty_inc = {1'b0, setting_r.base} + {8'h00, seq_bit};
    if (pass_wrap) begin
      seq_word = dither_seq(setting_nxt.factor);
      seq_bit  = seq_word[0];
      duty_inc = {1'b0, setting_nxt.base} + {8'h00, seq_bit};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      duty_r <= 8'h00;
    end else if (carrier_wrap) begin
      duty_r <= duty_inc[8] ? 8'hFF : duty_inc[7:0]; // [RULE3] [RULE5] [RULE6]
    end
  end

  // Slave channel: output high while the carrier is below duty/256 of the period.
  assign thresh_prod = duty_r * CARRIER_CYC[CW-1:0];
  assign thresh      = thresh_prod[CW+7:8];
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= (carrier_cnt_r < thresh); // [RULE1] [RULE2]
    end
  end

  // Event outputs: one pulse per load and one per completed pass.
  // The pass setting shows the new values in the same cycle as the reload pulse.
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      transfer_pulse <= 1'b0;
      reload_pulse   <= 1'b0;
      pass_setting   <= '0;
    end else begin
      transfer_pulse <= carrier_wrap; // [RULE12]
      reload_pulse   <= pass_wrap;    // [RULE12]
      if (pass_wrap) begin
        pass_setting <= setting_nxt; // [RULE14]
      end
    end
  end

  // Averaging: sum 16 consecutive ADC results; the sum over four is the 12-bit value.
  assign sum_nxt = sum_r + {4'h0, adc_in.data};
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      avg_cnt_r  <= 4'h0;
      sum_r      <= 14'h0000;
      meas_valid <= 1'b0;
      meas_value <= 12'h000;
    end else begin
      meas_valid <= 1'b0;
      if (adc_in.valid) begin
        avg_cnt_r <= avg_cnt_r + 4'h1;
        if (avg_cnt_r == 4'(`AVG_SAMPLES - 1)) begin
          sum_r      <= 14'h0000;
          meas_valid <= 1'b1;           // [RULE8]
          meas_value <= sum_nxt[13:2];  // [RULE8]
        end else begin
          sum_r <= sum_nxt;
        end
      end
    end
  end

  // Correction cadence: 16 measurements make one block of 256 samples.
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      block_cnt_r <= 4'h0;
    end else if (meas_valid) begin
      block_cnt_r <= block_cnt_r + 4'h1; // [RULE9]
    end
  end

  // Bang-bang loop: a new target or a mode change restarts from the target itself.
  always_ff @(posedge sys_clk or negedge rst_sync_n_r) begin
    if (!rst_sync_n_r) begin
      closed_code_r      <= `TARGET_RESET;
      target_prev_r      <= `TARGET_RESET;
      target_prev_mode_r <= 1'b0;
    end else begin
      target_prev_r      <= target_code;
      target_prev_mode_r <= loop_mode;
      if ((loop_mode != MODE_CLOSED) || (target_prev_mode_r != loop_mode) || (target_prev_r != target_code)) begin
        closed_code_r <= target_code; // [RULE7]
      end else if (meas_valid && (block_cnt_r == 4'((`CORR_SAMPLES / `AVG_SAMPLES) - 1))) begin
        if ((meas_value < target_code) && (closed_code_r != 12'hFFF)) begin
          closed_code_r <= closed_code_r + 12'h001; // [RULE9]
        end else if ((meas_value > target_code) && (closed_code_r != 12'h000)) begin
          closed_code_r <= closed_code_r - 12'h001; // [RULE9]
        end
      end
    end
  end

endmodule : pwm_dither_dac

// *** tb/pwm_dither_dac_properties.sv ***
`timescale 1ns/1ps
module pwm_dither_dac_checker
  import pwm_dither_dac_pkg::*;
#(parameter int CARRIER_CYC = 800) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [11:0] target_code,
  input wire pwm_dither_dac_pkg::loop_mode_e loop_mode,
  input wire pwm_dither_dac_pkg::adc_sample_s adc_in,
  input wire logic pwm_out,
  input wire logic transfer_pulse,
  input wire logic reload_pulse,
  input wire logic meas_valid,
  input wire logic [11:0] meas_value,
  input wire pwm_dither_dac_pkg::pass_setting_s pass_setting
);
  logic [15:0]   gap_r, hi_r, tot;
  logic [3:0]    trn_r, vld_r, stab_r;
  logic          seen_r, rl_r;
  pass_setting_s per_r;
  assign tot = hi_r + 16'(pwm_out);
  // High time in cycles of one duty code.
  function automatic int thr(input int d);
    return d * CARRIER_CYC / 256;
  endfunction : thr
  // Counts spacing, high time, loads per pass, samples and steady input cycles.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= '0;
      hi_r <= '0;
      trn_r <= '0;
      vld_r <= '0;
      stab_r <= '0;
      seen_r <= 1'b0;
      rl_r <= 1'b0;
      per_r <= '0;
    end else begin
      gap_r <= transfer_pulse ? '0 : gap_r + 16'h1;
      hi_r <= transfer_pulse ? '0 : tot;
      trn_r <= reload_pulse ? '0 : trn_r + 4'(transfer_pulse);
      vld_r <= vld_r + 4'(adc_in.valid);
      stab_r <= ($stable(target_code) && $stable(loop_mode)) ? stab_r + 4'(stab_r != 4'hF) : '0;
      seen_r <= seen_r | transfer_pulse;
      rl_r <= rl_r | reload_pulse;
      per_r <= transfer_pulse ? pass_setting : per_r;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  property p_period;
    transfer_pulse && seen_r |-> gap_r == 16'(CARRIER_CYC - 1);
  endproperty
  a_period: assert property (p_period) else $error("bad carrier period");
  property p_reload;
    reload_pulse |-> transfer_pulse;
  endproperty
  a_reload: assert property (p_reload) else $error("reload without load");
  property p_pass;
    reload_pulse && rl_r |-> trn_r == 4'hF;
  endproperty
  a_pass: assert property (p_pass) else $error("pass not 16 loads");
  property p_hold;
    $changed(pass_setting) |-> reload_pulse;
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed mid pass");
  property p_open;
    reload_pulse && stab_r == 4'hF && $past(loop_mode) == MODE_OPEN |-> pass_setting == $past(target_code);
  endproperty
  a_open: assert property (p_open) else $error("open setting wrong");
  property p_duty;
    transfer_pulse && seen_r |-> tot == 16'(thr(per_r.base)) ||
      tot == 16'(thr(per_r.base == 8'hFF ? 255 : per_r.base + 1));
  endproperty
  a_duty: assert property (p_duty) else $error("duty not base or base+1");
  property p_meas;
    $past(adc_in.valid) && vld_r == 4'h0 |-> meas_valid;
  endproperty
  a_meas: assert property (p_meas) else $error("no measurement");
  property p_one;
    meas_valid |=> !meas_valid;
  endproperty
  a_one: assert property (p_one) else $error("long meas pulse");
  property p_mhold;
    !meas_valid |-> $stable(meas_value);
  endproperty
  a_mhold: assert property (p_mhold) else $error("meas value moved");
endmodule : pwm_dither_dac_checker

bind pwm_dither_dac pwm_dither_dac_checker #(.CARRIER_CYC(CARRIER_CYC)) i_chk (
  .sys_clk, .resetn, .target_code, .loop_mode, .adc_in, .pwm_out,
  .transfer_pulse, .reload_pulse, .meas_valid, .meas_value, .pass_setting);

// *** tb/rc_adc_model.sv ***
`timescale 1ns/1ps
module rc_adc_model
  import pwm_dither_dac_pkg::*;
(
  input wire logic                        sys_clk,
  input wire logic                        resetn,
  input wire logic                        pwm_out,
  input wire logic                        enable,
  input wire logic [9:0]                  offset,
  output pwm_dither_dac_pkg::adc_sample_s adc_out
);
  logic [255:0] win_r;
  logic [8:0]   sum_r;
  logic [2:0]   div_r;
  // A 256-cycle moving average stands in for the filtered level.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      win_r <= '0;
      sum_r <= '0;
    end else begin
      win_r <= {win_r[254:0], pwm_out};
      sum_r <= sum_r + 9'(pwm_out) - 9'(win_r[255]);
    end
  end
  // Converts every eighth cycle; the data bus scrambles between samples.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      div_r <= '0;
      adc_out <= '0;
    end else begin
      div_r <= div_r + 3'h1;
      adc_out.valid <= enable && div_r == 3'h7;
      adc_out.data <= (div_r == 3'h7) ? 10'({sum_r, 2'b00}) + offset : ~adc_out.data;
    end
  end
endmodule : rc_adc_model

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import pwm_dither_dac_pkg::*;
  localparam int CC = 32;
  // Adder sequence per factor; bit k is used in period k of a pass.
  localparam logic [15:0] SEQ [16] = '{16'h0000, 16'h0001, 16'h0101, 16'h0421, 16'h1111, 16'h1249, 16'h2525,
    16'h2A55, 16'h5555, 16'hD5AA, 16'hDADA, 16'hEDB6, 16'hEEEE, 16'hFBDE, 16'hFEFE, 16'hFFFE};
  logic          sys_clk, resetn, use_model, pwm_out, transfer_pulse, reload_pulse, meas_valid;
  logic [11:0]   target_code, meas_value;
  logic [9:0]    offset;
  loop_mode_e    loop_mode;
  adc_sample_s   adc_tb, adc_mdl, adc_in;
  pass_setting_s pass_setting;
  int            num_errors, n_tests;
  assign adc_in = use_model ? adc_mdl : adc_tb;
  pwm_dither_dac #(.CARRIER_CYC(CC)) i_pwm_dither_dac (.sys_clk, .resetn, .target_code, .loop_mode,
    .adc_in, .pwm_out, .transfer_pulse, .reload_pulse, .meas_valid, .meas_value, .pass_setting);
  rc_adc_model i_rc_adc_model (.sys_clk, .resetn, .pwm_out, .enable(use_model), .offset, .adc_out(adc_mdl));
  // Compares one value and counts the outcome.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Waits for a pass boundary under a bound.
  task automatic wait_rl;
    int n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (reload_pulse !== 1'b1 && n < 2000);
    chk(16'(reload_pulse), 16'h1);
  endtask : wait_rl
  // Counts high cycles of one carrier period, ending at the next load.
  task automatic period(output logic [15:0] hi);
    hi = '0;
    do begin
      @(negedge sys_clk);
      hi += 16'(pwm_out === 1'b1);
    end while (transfer_pulse !== 1'b1);
  endtask : period
  // Sets a level and checks every period of a whole pass.
  task automatic t_open(input logic [11:0] code);
    logic [15:0] hi;
    logic [8:0]  d;
    @(posedge sys_clk) target_code <= code;
    wait_rl();
    wait_rl();
    chk({4'h0, pass_setting}, {4'h0, code});
    for (int k = 0; k < 16; k++) begin
      d = 9'(code[11:4]) + 9'(SEQ[code[3:0]][k]);
      if (d > 9'd255) d = 9'd255;
      period(hi);
      chk(hi, 16'(d * CC / 256));
    end
    $display("open %h done", code);
  endtask : t_open
  // Changes the level mid pass; the old setting must hold until the boundary.
  task automatic t_mid;
    wait_rl();
    repeat (100) @(posedge sys_clk);
    target_code <= 12'h3C5;
    repeat (200) @(negedge sys_clk);
    chk({4'h0, pass_setting}, 16'h0FFF);
    wait_rl();
    chk({4'h0, pass_setting}, 16'h03C5);
    $display("mid done");
  endtask : t_mid
  // Sends 16 back-to-back samples and checks the summed measurement.
  task automatic t_meas;
    logic [15:0] sum = '0;
    for (int i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      adc_tb.valid <= 1'b1;
      adc_tb.data <= 10'h3FF - 10'(i * 37);
      sum += 16'(10'h3FF - 10'(i * 37));
    end
    @(posedge sys_clk);
    adc_tb.valid <= 1'b0;
    adc_tb.data <= 10'h155;
    @(negedge sys_clk);
    chk(16'(meas_valid), 16'h1);
    chk(16'(meas_value), sum >> 2);
    $display("meas done");
  endtask : t_meas
  // Runs the loop with a measurement offset and checks the one-step correction.
  // Each run first returns to open loop for two passes so that it starts from the bare target.
  task automatic t_closed(input logic [9:0] offs, input logic [11:0] exp);
    @(posedge sys_clk);
    loop_mode <= MODE_OPEN;
    offset <= offs;
    wait_rl();
    wait_rl();
    chk({4'h0, pass_setting}, 16'h0800);
    @(posedge sys_clk) loop_mode <= MODE_CLOSED;
    for (int n = 0; n < 6000 && pass_setting === 12'h800; n++) @(negedge sys_clk);
    chk({4'h0, pass_setting}, {4'h0, exp});
    $display("closed %h done", offs);
  endtask : t_closed
  // Prints the counts and the verdict, then stops.
  task automatic results;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // Makes the 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Cuts a hang short.
  initial begin
    #1800000;
    num_errors++;
    results();
  end
  // Main sequence.
  initial begin
    {resetn, use_model, target_code, offset, adc_tb} = '0;
    loop_mode = MODE_OPEN;
    num_errors = 0;
    n_tests = 0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_meas();
    for (int f = 0; f < 16; f++) t_open({8'h80, 4'(f)});
    t_open(12'hFFF);
    t_mid();
    t_open(12'h800);
    @(posedge sys_clk) use_model <= 1'b1;
    t_closed(10'h000, 12'h800);
    t_closed(10'h004, 12'h7FF);
    t_closed(10'h3FC, 12'h801);
    results();
  end
endmodule : tb
